// ### core/lsms_top.sv
`timescale 1ns/100ps
module lsms_top
    import lsms_pkg::*;
#(
    parameter int TICK_CYC = TICK_US * CLK_MHZ
) (
    // core clock and reset
    input  wire logic              CLOCK,
    input  wire logic              RESET_N,
    // register load link
    input  wire logic              LINK_CLK,
    input  wire logic              LINK_RST_N,
    input  wire logic              LINK_WR,
    input  wire logic [3:0]        LINK_ADDR,
    input  wire logic [7:0]        LINK_DATA,
    input  wire logic              LINK_LOAD,
    // asynchronous pins
    input  wire logic              EXT_EN,
    input  wire logic [NCH-1:0]    DROPOUT,
    // current sources
    output logic [NCH-1:0][5:0]    LED_CODE,
    output logic [NCH-1:0]         LED_ON,
    output logic [NCH-1:0]         GPO_OUT,
    output logic [NCH-1:0]         GPO_OE,
    // charge pump
    output lsms_pump_t             PUMP_MODE,
    output logic                   PUMP_BYPASS,
    output logic                   PUMP_PH1,
    output logic                   PUMP_PH2,
    output logic [6:0]             SOFT_LEVEL,
    output logic                   SHUTDOWN
);
    // ---------------------------------------------
    // link domain: holding latches and handover
    // ---------------------------------------------
    logic [NREG-1:0][7:0] hold_q;
    logic [NREG-1:0][7:0] xfer_q;
    logic                 req_q;
    logic                 pend_q;
    logic                 lack_s1_q;
    logic                 lack_s2_q;
    logic                 busy;
    logic                 go;

    assign busy = req_q ^ lack_s2_q;
    assign go   = (LINK_LOAD | pend_q) & ~busy;

    // quick write fans channel one data to all nine channels
    always_ff @(posedge LINK_CLK) begin
        if (!LINK_RST_N) begin
            hold_q <= '0;
        end else if (LINK_WR && LINK_ADDR < 4'(NREG)) begin
            if (LINK_ADDR == 4'(IX_CH1) && hold_q[IX_CMD][1]) begin
                for (int k = 0; k < NCH; k++) begin
                    hold_q[IX_CH1+k] <= LINK_DATA;
                end
            end else begin
                hold_q[LINK_ADDR] <= LINK_DATA;
            end
        end
    end

    // snapshot stays frozen until the core acknowledges it
    always_ff @(posedge LINK_CLK) begin
        if (!LINK_RST_N) begin
            xfer_q <= '0;
            req_q  <= 1'b0;
            pend_q <= 1'b0;
        end else begin
            pend_q <= (LINK_LOAD | pend_q) & ~go;
            if (go) begin
                xfer_q <= hold_q;
                req_q  <= ~req_q;
            end
        end
    end

    // acknowledge back into the link domain
    logic ack_q;
    always_ff @(posedge LINK_CLK) begin
        if (!LINK_RST_N) begin
            lack_s1_q <= 1'b0;
            lack_s2_q <= 1'b0;
        end else begin
            lack_s1_q <= ack_q;
            lack_s2_q <= lack_s1_q;
        end
    end

    // ---------------------------------------------
    // core domain: synchronisers and register copy
    // ---------------------------------------------
    logic                 req_s1_q;
    logic                 req_s2_q;
    logic                 en_s1_q;
    logic                 en_s2_q;
    logic                 en_s3_q;
    logic [NCH-1:0]       drop_s1_q;
    logic [NCH-1:0]       drop_s2_q;
    logic [NREG-1:0][7:0] act_q;
    logic                 ld_q;

    always_ff @(posedge CLOCK) begin
        if (!RESET_N) begin
            req_s1_q  <= 1'b0;
            req_s2_q  <= 1'b0;
            en_s1_q   <= 1'b0;
            en_s2_q   <= 1'b0;
            en_s3_q   <= 1'b0;
            drop_s1_q <= '0;
            drop_s2_q <= '0;
        end else begin
            req_s1_q  <= req_q;
            req_s2_q  <= req_s1_q;
            en_s1_q   <= EXT_EN;
            en_s2_q   <= en_s1_q;
            en_s3_q   <= en_s2_q;
            drop_s1_q <= DROPOUT;
            drop_s2_q <= drop_s1_q;
        end
    end

    // xfer_q is stable while the toggles differ, so a word copy is safe
    always_ff @(posedge CLOCK) begin
        if (!RESET_N) begin
            act_q <= {NREG{REG_RST}};
            ack_q <= 1'b0;
            ld_q  <= 1'b0;
        end else begin
            ld_q <= req_s2_q ^ ack_q;
            if (req_s2_q ^ ack_q) begin
                act_q <= xfer_q;
                ack_q <= req_s2_q;
            end
        end
    end

    lsms_cmd_t      cmd;
    lsms_tim_t      tim;
    logic [NCH-1:0] pinsel;
    logic           en_fall;
    logic           en_rise;
    logic           auto_md;

    assign cmd     = lsms_cmd_t'(act_q[IX_CMD]);
    assign tim     = lsms_tim_t'(act_q[IX_TIM]);
    assign pinsel  = {tim.pin9, act_q[IX_SEL]};
    assign en_fall = en_s3_q & ~en_s2_q;
    assign en_rise = ~en_s3_q & en_s2_q;
    assign auto_md = cmd.force_sel == F_AUTO;

    // ---------------------------------------------
    // base tick, blink and gradation timers
    // ---------------------------------------------
    logic [11:0] tk_q;
    logic        tick;
    assign tick = tk_q == 12'(TICK_CYC - 1);

    always_ff @(posedge CLOCK) begin
        if (!RESET_N || tick) begin
            tk_q <= '0;
        end else begin
            tk_q <= tk_q + 12'h001;
        end
    end

    // blink timer restarts on every load so phases line up with the write
    logic [21:0] bl_q;
    logic [21:0] bl_per;
    logic [21:0] bl_on;
    logic        bl_end;
    logic        bl_lit;
    assign bl_per = tim.blink[1] ? BP_LONG : BP_SHORT;
    assign bl_on  = tim.blink[0] ? BL_SHORT : BL_LONG;
    assign bl_end = tick && bl_q == bl_per - 22'h000001;
    assign bl_lit = bl_q < bl_on;

    always_ff @(posedge CLOCK) begin
        if (!RESET_N || ld_q || bl_end) begin
            bl_q <= '0;
        end else if (tick) begin
            bl_q <= bl_q + 22'h000001;
        end
    end

    // gradation runs on its own counter, independent of blink
    logic [21:0] gr_q;
    logic [21:0] gr_top;
    logic        gstep;
    always_comb begin
        unique case (tim.grad)
            2'h1:    gr_top = GR_STEP1;
            2'h2:    gr_top = GR_STEP2;
            2'h3:    gr_top = GR_STEP3;
            default: gr_top = '0;
        endcase
    end
    assign gstep = tick && tim.grad != 2'h0 && gr_q == gr_top - 22'h000001;

    always_ff @(posedge CLOCK) begin
        if (!RESET_N || ld_q || gstep) begin
            gr_q <= '0;
        end else if (tick) begin
            gr_q <= gr_q + 22'h000001;
        end
    end

    // ---------------------------------------------
    // per-channel current control
    // ---------------------------------------------
    logic [NCH-1:0][5:0] lvl_q;
    logic [NCH-1:0][5:0] led_q;
    logic [NCH-1:0]      on_q;
    logic [NCH-1:0]      oe_q;
    logic [NCH-1:0]      gpo_q;
    logic [NCH-1:0]      drop_v;
    logic [NCH-1:0]      act_v;
    logic [NCH-1:0]      done_v;
    logic [NCH-1:0]      blink_v;

    for (genvar i = 0; i < NCH; i++) begin : g_ch
        lsms_chan_t c;
        logic       grd;
        logic       up_i;
        logic       off_pin;
        logic [5:0] tgt;
        logic [5:0] cur;
        assign c       = lsms_chan_t'(act_q[IX_CH1+i]);
        assign grd     = c.mode == M_GRAD && tim.grad != 2'h0;
        assign up_i    = pinsel[i] ? en_s2_q : cmd.up;
        assign tgt     = up_i ? c.code : 6'h00;
        assign off_pin = pinsel[i] & ~en_s2_q;
        assign blink_v[i] = c.mode == M_BLINK && c.code != 6'h00;
        // unprogrammed, open-drain and pin-gated channels never raise dropout
        assign drop_v[i] = drop_s2_q[i] && c.code != 6'h00
                           && c.mode != M_GPO && !off_pin;
        assign act_v[i]  = c.code != 6'h00
                           && !(off_pin && (!grd || lvl_q[i] == 6'h00));
        assign done_v[i] = grd && gstep && !up_i && lvl_q[i] == 6'h01;

        // ramp state; pin channels restart from zero on the rising edge
        always_ff @(posedge CLOCK) begin
            if (!RESET_N) begin
                lvl_q[i] <= 6'h00;
            end else if (ld_q) begin
                lvl_q[i] <= (pinsel[i] || cmd.up) ? 6'h00 : c.code;
            end else if (pinsel[i] && en_rise) begin
                lvl_q[i] <= 6'h00;
            end else if (grd && gstep && lvl_q[i] != tgt) begin
                lvl_q[i] <= (lvl_q[i] < tgt) ? lvl_q[i] + 6'h01
                                             : lvl_q[i] - 6'h01;
            end
        end

        // drive code: ramp level, blink gate, pin gate, open drain off
        always_comb begin
            cur = grd ? lvl_q[i] : c.code;
            if (c.mode == M_GPO) begin
                cur = 6'h00;
            end else if (c.mode == M_BLINK && !bl_lit) begin
                cur = 6'h00;
            end else if (off_pin && !grd) begin
                cur = 6'h00;
            end
        end

        always_ff @(posedge CLOCK) begin
            if (!RESET_N) begin
                led_q[i] <= 6'h00;
                on_q[i]  <= 1'b0;
                oe_q[i]  <= 1'b0;
                gpo_q[i] <= 1'b1;
            end else begin
                led_q[i] <= cur;
                on_q[i]  <= cur != 6'h00;
                oe_q[i]  <= c.mode == M_GPO && c.code != 6'h00;
                // own flop for the data level, so the pin needs no gate after the register
                gpo_q[i] <= !(c.mode == M_GPO && c.code != 6'h00);
            end
        end
    end

    // ---------------------------------------------
    // pump mode sequencer
    // ---------------------------------------------
    lsms_pump_t  mode_q;
    lsms_pump_t  prev_q;
    logic [21:0] dc_q;
    logic        shut_q;
    logic        any_drop;
    logic        to1x;
    logic        up_step;

    assign any_drop = |drop_v;
    assign to1x     = ld_q | (|done_v) | en_fall | (bl_end & (|blink_v));
    assign up_step  = auto_md && any_drop && tick && dc_q == DROP_TOP;

    // dropout must stay continuous; any gap restarts the wait
    always_ff @(posedge CLOCK) begin
        if (!RESET_N || !auto_md || !any_drop || to1x || up_step) begin
            dc_q <= '0;
        end else if (tick) begin
            dc_q <= dc_q + 22'h000001;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RESET_N) begin
            mode_q <= PM_1X;
        end else if (!auto_md) begin
            unique case (cmd.force_sel)
                F_HALF:  mode_q <= PM_1P5;
                F_DBL:   mode_q <= PM_2X;
                default: mode_q <= PM_1X;
            endcase
        end else if (shut_q || to1x) begin
            mode_q <= PM_1X;
        end else if (up_step) begin
            unique case (mode_q)
                PM_1X:   mode_q <= PM_1P5;
                PM_1P5:  mode_q <= PM_2X;
                PM_2X:   mode_q <= PM_2X;
                default: mode_q <= PM_1X;
            endcase
        end
    end

    // a forced mode may be feeding a load from the pump, so stay awake
    always_ff @(posedge CLOCK) begin
        if (!RESET_N) begin
            shut_q <= 1'b1;
        end else begin
            shut_q <= auto_md && !(|act_v);
        end
    end

    // ---------------------------------------------
    // soft-start and two-phase pump clock
    // ---------------------------------------------
    logic [6:0] ss_q;
    logic [6:0] pc_q;
    logic       run;
    logic       ph1_q;
    logic       ph2_q;
    logic       byp_q;
    assign run = mode_q != PM_1X && !shut_q;

    always_ff @(posedge CLOCK) begin
        if (!RESET_N) begin
            prev_q <= PM_1X;
            ss_q   <= 7'h00;
        end else begin
            prev_q <= mode_q;
            if (!run || mode_q != prev_q) begin
                ss_q <= 7'h00;
            end else if (tick && ss_q != SS_TOP) begin
                ss_q <= ss_q + 7'h01;
            end
        end
    end

    // free-running divider; dead bands at both phase edges avoid overlap
    always_ff @(posedge CLOCK) begin
        if (!RESET_N || pc_q == PC_TOP) begin
            pc_q <= 7'h00;
        end else begin
            pc_q <= pc_q + 7'h01;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (!RESET_N) begin
            ph1_q <= 1'b0;
            ph2_q <= 1'b0;
            byp_q <= 1'b0;
        end else begin
            ph1_q <= run && pc_q >= PC_DEAD && pc_q < PC_HALF - PC_DEAD;
            ph2_q <= run && pc_q >= PC_HALF + PC_DEAD && pc_q < PC_TOP - PC_DEAD;
            byp_q <= !shut_q && mode_q == PM_1X;
        end
    end

    assign LED_CODE    = led_q;
    assign LED_ON      = on_q;
    assign GPO_OE      = oe_q;
    assign GPO_OUT     = gpo_q;
    assign PUMP_MODE   = mode_q;
    assign PUMP_BYPASS = byp_q;
    assign PUMP_PH1    = ph1_q;
    assign PUMP_PH2    = ph2_q;
    assign SOFT_LEVEL  = ss_q;
    assign SHUTDOWN    = shut_q;

    // ---------------------------------------------
    // checks
    // ---------------------------------------------
    logic [23:0] drun_q;
    always_ff @(posedge CLOCK) begin
        if (!RESET_N || !any_drop) begin
            drun_q <= '0;
        end else if (drun_q != 24'hffffff) begin
            drun_q <= drun_q + 24'h000001;
        end
    end

    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RESET_N);

    a_shut_unity: assert property (
        (shut_q && auto_md) |=> mode_q == PM_1X) else $error("not unity in shutdown");
    a_first_step: assert property (
        (mode_q == PM_1X && up_step && !to1x && !shut_q) |=> mode_q == PM_1P5)
        else $error("missed step to half mode");
    a_drop_wait: assert property (
        up_step |-> drun_q >= 24'(int'(DROP_TOP) * TICK_CYC))
        else $error("step before dropout wait");
    a_load_unity: assert property (
        (auto_md && ld_q) |=> mode_q == PM_1X) else $error("load kept boost");
    a_force_dbl: assert property (
        cmd.force_sel == F_DBL |=> mode_q == PM_2X) else $error("double force lost");
    a_force_half: assert property (
        cmd.force_sel == F_HALF |=> mode_q == PM_1P5) else $error("half force lost");
    a_zero_off: assert property (
        (act_q[NCH:IX_CH1] == '0) |=> LED_ON == '0) else $error("zero code lit");
    a_force_awake: assert property (
        !auto_md |=> !shut_q) else $error("shutdown under force");
    a_ss_entry: assert property (
        (run && $changed(mode_q)) |=> ss_q == 7'h00 ##1 ss_q <= 7'h01)
        else $error("soft-start not restarted");
    a_phase_gap: assert property (
        $fell(PUMP_PH1) |-> !PUMP_PH2 [*2]) else $error("pump phases overlap");

    c_reach_dbl:  cover property (mode_q == PM_1P5 ##1 mode_q == PM_2X);
    c_blink_end:  cover property (bl_end && (|blink_v));
    c_ramp_done:  cover property (|done_v);
    c_pin_shut:   cover property (en_fall ##[1:1000] shut_q);
endmodule

// ### core/lsms_pkg.sv
package lsms_pkg;
    // ---------------------------------------------
    // register map and fields
    // ---------------------------------------------
    localparam int NCH    = 9;
    localparam int NREG   = 12;
    localparam int IX_CMD = 0;
    localparam int IX_CH1 = 1;
    localparam int IX_SEL = 10;
    localparam int IX_TIM = 11;
    localparam logic [7:0] REG_RST = 8'h00;
    localparam logic [1:0] M_NORM  = 2'h0;
    localparam logic [1:0] M_BLINK = 2'h1;
    localparam logic [1:0] M_GRAD  = 2'h2;
    localparam logic [1:0] M_GPO   = 2'h3;
    localparam logic [1:0] F_AUTO  = 2'h0;
    localparam logic [1:0] F_HALF  = 2'h1;
    localparam logic [1:0] F_DBL   = 2'h2;
    localparam logic [1:0] F_ONE   = 2'h3;
    // ---------------------------------------------
    // timing, counts in base ticks except the pump divider counts, which are in core clocks
    // ---------------------------------------------
    localparam int CLK_MHZ  = 100;
    localparam int TICK_US  = 1;
    localparam int DROP_US  = 400;
    localparam int SS_US    = 125;
    localparam int PUMP_KHZ = 850;
    localparam int PUMP_DIV = (CLK_MHZ * 1000) / PUMP_KHZ;
    localparam int NSTEP    = 64;
    localparam logic [21:0] DROP_TOP = 22'(DROP_US / TICK_US - 1);
    localparam logic [6:0]  SS_TOP   = 7'(SS_US / TICK_US);
    localparam logic [6:0]  PC_TOP   = 7'(PUMP_DIV - 1);
    localparam logic [6:0]  PC_HALF  = 7'(PUMP_DIV / 2);
    localparam logic [6:0]  PC_DEAD  = 7'h02;
    localparam logic [21:0] BL_SHORT = 22'(156000 / TICK_US);
    localparam logic [21:0] BL_LONG  = 22'(625000 / TICK_US);
    localparam logic [21:0] BP_SHORT = 22'(1250000 / TICK_US);
    localparam logic [21:0] BP_LONG  = 22'(2500000 / TICK_US);
    localparam logic [21:0] GR_STEP1 = 22'(240000 / TICK_US / NSTEP);
    localparam logic [21:0] GR_STEP2 = 22'(480000 / TICK_US / NSTEP);
    localparam logic [21:0] GR_STEP3 = 22'(960000 / TICK_US / NSTEP);
    // ---------------------------------------------
    // carriers
    // ---------------------------------------------
    typedef struct packed {
        logic [1:0] mode;
        logic [5:0] code;
    } lsms_chan_t;
    typedef struct packed {
        logic [3:0] rsv;
        logic [1:0] force_sel;
        logic       quick;
        logic       up;
    } lsms_cmd_t;
    typedef struct packed {
        logic [2:0] rsv;
        logic [1:0] blink;
        logic [1:0] grad;
        logic       pin9;
    } lsms_tim_t;
    typedef enum logic [1:0] {PM_1X, PM_1P5, PM_2X} lsms_pump_t;
endpackage

// ### verification/lsms_host_model.sv
`timescale 1ns/100ps
// ---------------------------------------------
// host side: register writes, loads, enable pin
// ---------------------------------------------
module lsms_host_model
    import lsms_pkg::*;
(
    // link clock
    input  wire logic       link_clk,
    // link strobes
    output logic            link_wr,
    output logic [3:0]      link_addr,
    output logic [7:0]      link_data,
    output logic            link_load,
    // enable pin
    output logic            ext_en
);
    // idle values at time zero, pin parked low so pin outputs may be set up
    initial begin
        link_wr   = 1'b0;
        link_load = 1'b0;
        link_addr = 4'h0;
        link_data = 8'h00;
        ext_en    = 1'b0;
    end
    // one byte per strobe; released lines show the inverse, not a stale copy
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(negedge link_clk);
        link_wr   = 1'b1;
        link_addr = a;
        link_data = d;
        @(negedge link_clk);
        link_wr   = 1'b0;
        link_addr = ~a;
        link_data = ~d;
    endtask
    // load pulse, then allow the handover acknowledge to come back
    task automatic load();
        @(negedge link_clk);
        link_load = 1'b1;
        @(negedge link_clk);
        link_load = 1'b0;
        repeat (3) @(negedge link_clk);
    endtask
    // enable pin level, driven at once with no clock alignment
    task automatic set_en(input logic v);
        ext_en = v;
    endtask
endmodule

// ### verification/tb_lsms_top.sv
`timescale 1ns/100ps
module tb_lsms_top
    import lsms_pkg::*;
;
    // ---------------------------------------------
    // signals
    // ---------------------------------------------
    localparam int TK = 2;
    logic                clock, reset_n, link_clk, link_rst_n, link_wr, link_load, ext_en;
    logic [3:0]          link_addr;
    logic [7:0]          link_data;
    logic [NCH-1:0]      dropout, led_on, gpo_out, gpo_oe;
    logic [NCH-1:0][5:0] led_code;
    lsms_pump_t          pump_mode;
    logic                bypass, ph1, ph2, shutdown, p, q;
    logic [6:0]          soft_level;
    int                  failures, total_checks, n, r1, r2, ov;
    logic [7:0]          fc [4] = '{8'h04, 8'h08, 8'h0c, 8'h00};
    lsms_pump_t          fm [4] = '{PM_1P5, PM_2X, PM_1X, PM_1X};
    // clocks: link clock offset so the two never share an edge pattern
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    initial begin
        link_clk = 1'b0;
        #37;
        forever #80 link_clk = ~link_clk;
    end
    lsms_top #(.TICK_CYC(TK)) lsms_top_inst (
        .CLOCK(clock), .RESET_N(reset_n), .LINK_CLK(link_clk), .LINK_RST_N(link_rst_n),
        .LINK_WR(link_wr), .LINK_ADDR(link_addr), .LINK_DATA(link_data),
        .LINK_LOAD(link_load), .EXT_EN(ext_en), .DROPOUT(dropout), .LED_CODE(led_code),
        .LED_ON(led_on), .GPO_OUT(gpo_out), .GPO_OE(gpo_oe), .PUMP_MODE(pump_mode),
        .PUMP_BYPASS(bypass), .PUMP_PH1(ph1), .PUMP_PH2(ph2), .SOFT_LEVEL(soft_level),
        .SHUTDOWN(shutdown));
    lsms_host_model lsms_host_model_inst (
        .link_clk(link_clk), .link_wr(link_wr), .link_addr(link_addr),
        .link_data(link_data), .link_load(link_load), .ext_en(ext_en));
    // ---------------------------------------------
    // compare and sequencing tasks
    // ---------------------------------------------
    task automatic chk_val(input string nm, input logic [7:0] e, input logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            failures++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_mode(input string nm, input lsms_pump_t e);
        total_checks++;
        if (pump_mode !== e) begin
            failures++;
            $display("ERROR %s expected %0d seen %0d", nm, e, pump_mode);
        end
    endtask
    task automatic test_done();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic settle(input int c);
        repeat (c) @(negedge clock);
    endtask
    // one register write and a load, then let the handover land in the core
    task automatic cfg(input logic [3:0] a, input logic [7:0] d);
        lsms_host_model_inst.wr(a, d);
        lsms_host_model_inst.load();
        settle(20);
    endtask
    // bounded wait; a miss ends the run at once
    task automatic wait_mode(input lsms_pump_t e, input int mx);
        n = 0;
        while (pump_mode !== e && n < mx) begin
            @(negedge clock);
            n++;
        end
        if (pump_mode !== e) begin
            failures++;
            $display("ERROR pump_mode expected %0d seen %0d", e, pump_mode);
            test_done();
        end
    endtask
    // ---------------------------------------------
    // main sequence
    // ---------------------------------------------
    initial begin
        failures = 0;
        total_checks = 0;
        reset_n = 1'b0;
        link_rst_n = 1'b0;
        dropout = '0;
        settle(20);
        repeat (2) @(negedge link_clk);
        link_rst_n = 1'b1;
        @(negedge clock);
        reset_n = 1'b1;
        settle(2);
        chk_mode("reset_mode", PM_1X);
        chk_val("reset_shutdown", 8'h01, {7'h0, shutdown});
        // full-scale code, then dropout too short and then long enough
        cfg(4'h1, 8'h3f);
        chk_val("code1", 8'h3f, {2'h0, led_code[0]});
        chk_val("bypass", 8'h01, {7'h0, bypass});
        dropout[0] = 1'b1;
        settle(600);
        dropout[0] = 1'b0;
        settle(10);
        chk_mode("short_drop", PM_1X);
        dropout[0] = 1'b1;
        wait_mode(PM_1P5, 1000);
        chk_val("step_delay", 8'h01, {7'h0, n >= 795 && n <= 815});
        wait_mode(PM_2X, 1000);
        // soft-start restarts the cycle after the mode register changes
        settle(2);
        chk_val("soft_start", 8'h01, {7'h0, soft_level < 7'd5});
        // pump phases over ten divider periods
        r1 = 0;
        r2 = 0;
        ov = 0;
        p = ph1;
        q = ph2;
        repeat (1170) begin
            @(negedge clock);
            if (ph1 === 1'b1 && p === 1'b0) r1++;
            if (ph2 === 1'b1 && q === 1'b0) r2++;
            if (ph1 === 1'b1 && ph2 === 1'b1) ov++;
            p = ph1;
            q = ph2;
        end
        chk_val("ph_rises", 8'd10, r1[7:0]);
        chk_val("ph2_rises", 8'd10, r2[7:0]);
        chk_val("ph_overlap", 8'd0, ov[7:0]);
        chk_val("soft_full", 8'd125, {1'b0, soft_level});
        chk_val("boost_bypass", 8'h00, {7'h0, bypass});
        dropout[0] = 1'b0;
        cfg(4'h1, 8'h3f);
        chk_mode("load_to_unity", PM_1X);
        // every force code, then dropout while forced
        for (int i = 0; i < 4; i++) begin
            cfg(4'h0, fc[i]);
            chk_mode("force", fm[i]);
        end
        cfg(4'h0, 8'h04);
        dropout[0] = 1'b1;
        settle(1000);
        chk_mode("forced_hold", PM_1P5);
        dropout[0] = 1'b0;
        cfg(4'h0, 8'h00);
        // unprogrammed and open-drain channels must not step the pump
        cfg(4'h1, 8'h00);
        cfg(4'h2, 8'hc5);
        cfg(4'h3, 8'h10);
        chk_val("led_on1", 8'h00, {7'h0, led_on[0]});
        chk_val("gpo_oe2", 8'h01, {7'h0, gpo_oe[1]});
        chk_val("gpo_out2", 8'h00, {7'h0, gpo_out[1]});
        dropout = 9'h003;
        settle(1000);
        chk_mode("ignored_drop", PM_1X);
        dropout = '0;
        // all codes zero, then a force keeps the device awake
        cfg(4'h2, 8'h00);
        cfg(4'h3, 8'h00);
        chk_val("zero_shutdown", 8'h01, {7'h0, shutdown});
        cfg(4'h0, 8'h0c);
        chk_val("forced_awake", 8'h00, {7'h0, shutdown});
        cfg(4'h0, 8'h00);
        // pin-controlled channel one, set up while the pin is low
        cfg(4'ha, 8'h01);
        cfg(4'h1, 8'h20);
        chk_val("pin_low_code", 8'h00, {2'h0, led_code[0]});
        chk_val("pin_low_sd", 8'h01, {7'h0, shutdown});
        dropout[0] = 1'b1;
        settle(1000);
        chk_mode("pin_low_drop", PM_1X);
        dropout[0] = 1'b0;
        lsms_host_model_inst.set_en(1'b1);
        settle(20);
        chk_val("pin_high_code", 8'h20, {2'h0, led_code[0]});
        lsms_host_model_inst.set_en(1'b0);
        settle(20);
        chk_val("pin_fall_code", 8'h00, {2'h0, led_code[0]});
        chk_val("pin_fall_sd", 8'h01, {7'h0, shutdown});
        // gradation down from code one; its completion drops the boost
        cfg(4'ha, 8'h00);
        cfg(4'hb, 8'h02);
        cfg(4'h1, 8'h81);
        chk_val("grad_start", 8'h01, {2'h0, led_code[0]});
        dropout[0] = 1'b1;
        wait_mode(PM_1P5, 1000);
        dropout[0] = 1'b0;
        settle(6000);
        chk_val("grad_hold", 8'h01, {2'h0, led_code[0]});
        wait_mode(PM_1X, 1500);
        settle(2);
        chk_val("grad_end", 8'h00, {2'h0, led_code[0]});
        // quick write fans channel one data out to every channel
        cfg(4'h0, 8'h02);
        cfg(4'h1, 8'h07);
        chk_val("quick_ch9", 8'h07, {2'h0, led_code[8]});
        test_done();
    end
endmodule
